/* bench/delay_cfg_properties.sv */
`timescale 1ns/1ps
module delay_cfg_properties (
  // system
  input wire logic clock,
  input wire logic rst_n,
  // serial link
  input wire logic config_serial_clock,
  input wire logic config_serial_pin,
  input wire logic config_latch_strobe
);
  logic sck, sd, ld;
  logic [3:0] rises;
  assign sck = config_serial_clock;
  assign sd = config_serial_pin;
  assign ld = config_latch_strobe;
  // rises per frame, cleared once the latch closes
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      rises <= 4'h0;
    else if ($fell(ld))
      rises <= 4'h0;
    else if ($rose(sck))
      rises <= rises + 4'h1;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  strobe_len_a: assert property ($rose(ld) |-> ld[*4] ##1 !ld)
    else $error("strobe width");
  strobe_count_a: assert property ($rose(ld) |-> rises == 4'hB)
    else $error("bits before strobe");
  frame_bits_a: assert property (rises == 4'hB |-> !$rose(sck))
    else $error("extra bit");
  sclk_high_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("sclk high time");
  sclk_low_a: assert property ($fell(sck) && rises != 4'hB |-> !sck[*4] ##1 sck)
    else $error("sclk low time");
  data_hold_a: assert property (sck |-> $stable(sd))
    else $error("data moved");
  strobe_quiet_a: assert property (ld |-> !sck && $stable(sd))
    else $error("link busy in latch");
  strobe_gap_a: assert property ($fell(ld) |-> !ld[*4])
    else $error("strobe gap");
endmodule : delay_cfg_properties

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import delay_cfg_pkg::*;
  logic clock = 0, rst_n = 0, valid = 0, ch = 0, md = 0, zin = 0;
  logic m, em = 0, ready, qt, qc, def, feed, zin1 = 0;
  delay_code_t code = 9'h000, d0, d1, e0 = 9'h000, e1 = 9'h000;
  delay_code_t codes [5] = '{9'h1FF, 9'h155, 9'h0AA, 9'h100, 9'h001};
  int failures = 0, n_checks = 0;
  delay_cfg_link link();
  serial_delay_config_loader serial_delay_config_loader_inst (.clock(clock), .rst_n(rst_n),
    .link(link.loader), .delay_channel_zero(d0), .delay_channel_one(d1),
    .cascade_mode_bit(m), .channel_zero_output(zin), .channel_zero_true(qt),
    .channel_zero_comp(qc), .config_defined(def), .channel_one_input(zin1),
    .channel_one_feed(feed));
  serial_delay_config_driver serial_delay_config_driver_inst (.clock(clock), .rst_n(rst_n),
    .load_valid(valid), .load_ready(ready), .load_channel(ch), .load_cascade(md),
    .load_code(code), .link(link.controller));
  delay_cfg_properties delay_cfg_properties_inst (.clock(clock), .rst_n(rst_n),
    .config_serial_clock(link.config_serial_clock),
    .config_serial_pin(link.config_serial_pin),
    .config_latch_strobe(link.config_latch_strobe));
  initial forever #25 clock = ~clock;
  task automatic check(string name, logic [8:0] exp, logic [8:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // ready returns only after strobe and gap, so outputs are settled
  task automatic send(logic c, logic k, delay_code_t v);
    @(negedge clock);
    {ch, md, code, valid} = {c, k, v, 1'b1};
    @(negedge clock);
    valid = 0;
    for (int t = 0; t < 300 && ready !== 1'b1; t++)
      @(negedge clock);
  endtask : send
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  initial
  begin
    repeat (4) @(posedge clock);
    @(negedge clock) rst_n = 1;
    check("chan0", 9'h000, d0);
    check("chan1", 9'h000, d1);
    check("defined", 9'h000, {8'h00, def});
    for (int i = 0; i < 5; i++)
    begin
      send(i[0], i[1], codes[i]);
      if (i[0])
        e1 = codes[i];
      else
        e0 = codes[i];
      em = i[1];
      zin = i[0];
      zin1 = ~i[0];
      #1;
      check("defined", {8'h00, i != 0}, {8'h00, def});
      check("feed", {8'h00, em ? zin : zin1}, {8'h00, feed});
      check("chan0", e0, d0);
      check("chan1", e1, d1);
      check("mode", {8'h00, em}, {8'h00, m});
      check("true", {8'h00, ~em & zin}, {8'h00, qt});
      check("comp", {8'h00, em | ~zin}, {8'h00, qc});
    end
    results();
  end
  // five frames need about 500 cycles
  initial
  begin
    repeat (2000) @(posedge clock);
    failures++;
    results();
  end
endmodule : testbench

/* src/delay_cfg_defines.svh */
`ifndef DELAY_CFG_DEFINES_SVH
`define DELAY_CFG_DEFINES_SVH
// word layout, lsb shifted first
`define CFG_WORD_BITS 11
`define CFG_SEL_POS 0
`define CFG_MODE_POS 1
`define CFG_CODE_LSB 2
`define CFG_CODE_MSB 10
`define CFG_CODE_BITS 9
// reset values
`define CFG_CODE_RESET 9'h000
`define CFG_WORD_RESET 11'h000
// controller timing, serial clock from a divider
`define CLOCK_PERIOD_NS 50
`define SERIAL_PERIOD_NS 400
`define SERIAL_HALF_CYCLES ((`SERIAL_PERIOD_NS / 2) / `CLOCK_PERIOD_NS)
`define STROBE_HIGH_CYCLES 4
`endif

/* src/delay_cfg_link.sv */
`timescale 1ns/1ps
interface delay_cfg_link;
  logic config_serial_clock;
  logic config_serial_pin;
  logic config_latch_strobe;
  modport loader (
    input config_serial_clock,
    input config_serial_pin,
    input config_latch_strobe
  );
  modport controller (
    output config_serial_clock,
    output config_serial_pin,
    output config_latch_strobe
  );
endinterface : delay_cfg_link

/* src/delay_cfg_pkg.sv */
package delay_cfg_pkg;
  typedef logic [8:0] delay_code_t;
  typedef logic [10:0] cfg_word_t;
endpackage : delay_cfg_pkg

/* src/serial_delay_config_driver.sv */
`timescale 1ns/1ps
`include "delay_cfg_defines.svh"
module serial_delay_config_driver
  import delay_cfg_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_n,
  // user request
  input wire logic load_valid,
  output logic load_ready,
  input wire logic load_channel,
  input wire logic load_cascade,
  input wire delay_cfg_pkg::delay_code_t load_code,
  // serial link
  delay_cfg_link.controller link
);
  import delay_cfg_pkg::*;

  typedef enum logic [3:0] {
    IDLE = 4'b0001,
    SHIFT = 4'b0010,
    STROBE = 4'b0100,
    GAP = 4'b1000
  } drv_state_t;

  localparam int HALF = `SERIAL_HALF_CYCLES;
  drv_state_t state;
  cfg_word_t word;
  logic [3:0] bit_cnt;
  logic [7:0] tick_cnt;
  logic sclk;
  logic config_serial_in;
  logic strobe;
  logic tick;

  // divider: 400 ns serial period keeps us far under 20 MHz
  assign tick = (tick_cnt == 8'(HALF - 1));
  assign load_ready = (state == IDLE);
  assign link.config_serial_clock = sclk;
  assign link.config_serial_pin = config_serial_in;
  assign link.config_latch_strobe = strobe;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tick_cnt <= 8'h00;
    else if (state == IDLE || tick)
      tick_cnt <= 8'h00;
    else
      tick_cnt <= tick_cnt + 8'h01;
  end

  // one word per request, for the channel on load_channel
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= IDLE;
      word <= `CFG_WORD_RESET;
      bit_cnt <= 4'h0;
      sclk <= 1'b0;
      config_serial_in <= 1'b0;
      strobe <= 1'b0;
    end
    else
    begin
      unique case (state)
        IDLE:
          if (load_valid)
          begin
            // select lsb, mode next, code above
            word <= {load_code, load_cascade, load_channel};
            config_serial_in <= load_channel;
            bit_cnt <= 4'h0;
            sclk <= 1'b0;
            state <= SHIFT;
          end
        SHIFT:
          if (tick)
          begin
            // data moves on the falling edge, half a period clear of the rise
            if (sclk && bit_cnt == 4'(`CFG_WORD_BITS - 1))
              state <= STROBE;
            else if (sclk)
            begin
              config_serial_in <= word[1];
              word <= {1'b0, word[`CFG_WORD_BITS-1:1]};
              bit_cnt <= bit_cnt + 4'h1;
            end
            sclk <= !sclk;
          end
        STROBE:
          begin
            // strobe raised only with sclk low so no shift can overlap it
            strobe <= 1'b1;
            if (tick)
              state <= GAP;
          end
        GAP:
          begin
            strobe <= 1'b0;
            if (tick)
              state <= IDLE;
          end
      endcase
    end
  end
endmodule : serial_delay_config_driver

/* src/serial_delay_config_loader.sv */
`timescale 1ns/1ps
// Function
// - configure only via 11-bit shift register
// - word is select, mode, 9-bit code
// - controller sends one word per channel
// - two words after power-up define both
// - lsb select, then mode, then code
// - dual channel zero: mode 0, select 0
// - dual channel one: mode 0, select 1
// - extended words carry mode 1
// - controller serial clock at most 20 MHz
// - shift on serial clock rising edge
// - latch transparent while strobe high
// - select bit first, code msb last
// - cascade feeds channel one, mutes channel zero
`include "delay_cfg_defines.svh"
module serial_delay_config_loader
  import delay_cfg_pkg::*;
(
  // system
  input wire logic clock,
  input wire logic rst_n,
  // serial link
  delay_cfg_link.loader link,
  // delay channel control
  output delay_cfg_pkg::delay_code_t delay_channel_zero,
  output delay_cfg_pkg::delay_code_t delay_channel_one,
  output logic cascade_mode_bit,
  output logic config_defined,
  // channel zero output gating
  input wire logic channel_zero_output,
  output logic channel_zero_true,
  output logic channel_zero_comp,
  // channel one input routing
  input wire logic channel_one_input,
  output logic channel_one_feed
);
  import delay_cfg_pkg::*;

  // pin positions in the synchroniser bank
  localparam int PINS = 3;
  localparam int PIN_SCLK = 0;
  localparam int PIN_DATA = 1;
  localparam int PIN_STROBE = 2;

  // synchronised pins and serial clock edge
  wire logic [PINS-1:0] pin_raw;
  wire logic [PINS-1:0] pin_sync;
  logic sclk_prev;
  logic sclk_rise;

  // serial word and its fields
  cfg_word_t shift_word;
  cfg_word_t next_shift_word;
  logic word_select;
  logic word_mode;
  delay_code_t word_code;

  // latch control and power-up tracking
  logic latch_open;
  logic load_zero;
  logic load_one;
  logic zero_seen;
  logic one_seen;

  assign pin_raw[PIN_SCLK] = link.config_serial_clock;
  assign pin_raw[PIN_DATA] = link.config_serial_pin;
  assign pin_raw[PIN_STROBE] = link.config_latch_strobe;

  // two stages per pin; logic reads only the second
  for (genvar p = 0; p < PINS; p++)
  begin : pin_sync_gen
    logic stage_one;
    logic stage_two;

    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        stage_one <= 1'b0;
        stage_two <= 1'b0;
      end
      else
      begin
        stage_one <= pin_raw[p];
        stage_two <= stage_one;
      end
    end

    assign pin_sync[p] = stage_two;
  end

  // resets to the idle pin level, so no false edge after reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sclk_prev <= 1'b0;
    else
      sclk_prev <= pin_sync[PIN_SCLK];
  end

  assign sclk_rise = pin_sync[PIN_SCLK] && !sclk_prev;

  // new bits enter at the top so the first bit ends at bit 0
  always_comb
  begin
    next_shift_word = shift_word;
    if (sclk_rise)
      next_shift_word = {pin_sync[PIN_DATA], shift_word[`CFG_WORD_BITS-1:1]};
  end

  // bits move only on a synchronised rising edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      shift_word <= `CFG_WORD_RESET;
    else
      shift_word <= next_shift_word;
  end

  // fields of the word in the shift register
  assign word_select = shift_word[`CFG_SEL_POS];
  assign word_mode = shift_word[`CFG_MODE_POS];
  assign word_code = shift_word[`CFG_CODE_MSB:`CFG_CODE_LSB];

  // clocked stand-in for a transparent latch; shifting under a high strobe is tracked
  assign latch_open = pin_sync[PIN_STROBE];
  assign load_zero = latch_open && !word_select;
  assign load_one = latch_open && word_select;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      delay_channel_zero <= `CFG_CODE_RESET;
    else if (load_zero)
      delay_channel_zero <= word_code;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      delay_channel_one <= `CFG_CODE_RESET;
    else if (load_one)
      delay_channel_one <= word_code;
  end

  // one mode latch for both channels, last word wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cascade_mode_bit <= 1'b0;
    else if (latch_open)
      cascade_mode_bit <= word_mode;
  end

  // codes read zero after reset but mean nothing until loaded
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      zero_seen <= 1'b0;
    else if (load_zero)
      zero_seen <= 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      one_seen <= 1'b0;
    else if (load_one)
      one_seen <= 1'b1;
  end

  // both channels need a word of their own
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      config_defined <= 1'b0;
    else
      config_defined <= (zero_seen || load_zero) && (one_seen || load_one);
  end

  // muted pair in cascade mode: true low, complement high
  always_comb
  begin
    if (cascade_mode_bit)
    begin
      channel_zero_true = 1'b0;
      channel_zero_comp = 1'b1;
    end
    else
    begin
      channel_zero_true = channel_zero_output;
      channel_zero_comp = !channel_zero_output;
    end
  end

  // cascade sends channel zero's output into channel one
  always_comb
  begin
    if (cascade_mode_bit)
      channel_one_feed = channel_zero_output;
    else
      channel_one_feed = channel_one_input;
  end
endmodule : serial_delay_config_loader
